// ===== hw/pdm_ctrl.sv
// Power-down mode controller: sleep, software and hardware standby
//
// How it works
// - Three modes: sleep, software standby, hardware standby.
// - Halt with select bit 0 enters sleep.
// - Halt with select bit 1 enters software standby.
// - Select bit is control bit 7, resets 0.
// - Select bit survives interrupt wake; software clears.
// - Bits 6..4 choose interrupt-wake settling wait.
// - Baseline codes 8K..128K states; 11x unused.
// - Flash variant code 101 gives 1,024 states.
// - Enabled interrupt ends sleep, starts handling.
// - Disabled module interrupt never wakes sleep.
// - Mask set at halt: only NMI wakes.
// - Reset pin low in sleep enters reset.
// - Standby pin low in sleep: hardware standby.
// - Software standby left by NMI, IRQ, pins.
// - Standby pin low anywhere: hardware standby.
// - Leave hardware standby: pin high, reset rises.
//
// Pins are synchronised, so pin action lands two cycles late.
// The standby pin outranks every other request in every state.
// The settling counter only runs on interrupt wake from standby;
// pin exits rely on the reset pin being held long enough instead.
// Unused settle codes fall back to the longest wait, trading time
// for safety; the status register flags them as invalid.
`timescale 1ns/1ps
`include "pdm_defines.svh"
module pdm_ctrl #(
    parameter logic FLASH_VARIANT = 1'b0   // Selects code 101 meaning
) (
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst_n,
    // Register port
    input  wire logic [`PDM_ADDR_W-1:0]  i_addr,
    input  wire logic [7:0]              i_wdata,
    input  wire logic                    i_wr,
    input  wire logic                    i_rd,
    output logic      [7:0]              o_rdata,
    // CPU core side
    input  wire logic                    i_halt_exec,
    input  wire logic                    i_cpu_imask,
    input  wire logic                    i_int_req,
    input  wire logic                    i_nmi_req,
    input  wire logic                    i_ext_irq_req,
    // Pins, asynchronous
    input  wire logic                    i_chip_clear_pin_n,
    input  wire logic                    i_hw_standby_pin_n,
    // Control outputs
    output logic                         o_cpu_halt,
    output logic                         o_clk_gate_n,
    output logic                         o_osc_run,
    output logic                         o_mod_halt,
    output logic                         o_mod_init,
    output logic                         o_port_hiz,
    output logic                         o_int_start,
    output logic                         o_reset_seq,
    output logic      [2:0]              o_mode
);
    pdm_pkg::pdm_state_t state_reg;      // Current power state
    pdm_pkg::pdm_state_t state_next;     // Combinational next state
    logic [7:0]          ctrl_reg;       // System power control image
    logic [`PDM_CNT_W-1:0] cnt_reg;      // Settling down-counter
    logic [`PDM_CNT_W-1:0] settle_cnt;   // Decoded wait length
    logic                settle_ok;      // Code is a used one
    logic                imask_reg;      // Mask captured at halt
    logic                clr_pin_n;      // Synchronised reset pin
    logic                hw_standby_pin_n_pin_n;     // Synchronised standby pin
    logic                clr_seen_reg;   // Reset pin seen low
    logic                rst_src_reg;    // Reset-source flag, set by i_rst_n and pin rise
    logic                wake_sleep;     // Sleep wake qualifier
    logic                wake_sw;        // Software standby wake

    // Pins cross into the system clock domain first
    // Two cycles of latency; only the second stage reads the first
    pdm_sync #(.RST_VAL(1'b1)) u_sync_clr (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_chip_clear_pin_n),
        .o_sync    (clr_pin_n)
    );
    pdm_sync #(.RST_VAL(1'b1)) u_sync_hw_standby_pin_n (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_async   (i_hw_standby_pin_n),
        .o_sync    (hw_standby_pin_n_pin_n)
    );

    // Wait length from the current code
    // Decoder is pure logic; the variant is fixed per build
    pdm_settle_decode u_decode (
        .i_code          (ctrl_reg[`PDM_BIT_STS_HI:`PDM_BIT_STS_LO]),
        .i_flash_variant (FLASH_VARIANT),
        .o_count         (settle_cnt),
        .o_valid         (settle_ok)
    );

    // Module interrupt enables are already folded into i_int_req
    assign wake_sleep = i_nmi_req | (i_int_req & ~imask_reg);
    // Only NMI and the wake-capable external lines wake software standby; the clear pin leaves it via reset, the standby pin via hardware standby
    assign wake_sw    = i_nmi_req | i_ext_irq_req;

    // Next-state decision; standby pin outranks everything
    // Reset pin comes next, then wake requests
    // Halt outside run is ignored by construction
    always_comb begin
        state_next = state_reg;
        if (!hw_standby_pin_n_pin_n) begin
            state_next = pdm_pkg::PDM_HW_HW_STANDBY_PIN_N;
        end else begin
            unique case (state_reg)
                // Program execution
                pdm_pkg::PDM_RUN: begin
                    if (!clr_pin_n) begin
                        state_next = pdm_pkg::PDM_RESET;
                    end else if (i_halt_exec) begin
                        // Select bit chooses sleep or standby
                        state_next = ctrl_reg[`PDM_BIT_HW_STANDBY_PIN_N_SEL]
                                   ? pdm_pkg::PDM_SW_HW_STANDBY_PIN_N
                                   : pdm_pkg::PDM_SLEEP;
                    end
                end
                // Clock runs, CPU waits for a qualified interrupt
                pdm_pkg::PDM_SLEEP: begin
                    if (!clr_pin_n) begin
                        state_next = pdm_pkg::PDM_RESET;
                    end else if (wake_sleep) begin
                        state_next = pdm_pkg::PDM_RUN;
                    end
                end
                // Everything stopped until a wake-capable request
                pdm_pkg::PDM_SW_HW_STANDBY_PIN_N: begin
                    if (!clr_pin_n) begin
                        state_next = pdm_pkg::PDM_RESET;
                    end else if (wake_sw) begin
                        state_next = pdm_pkg::PDM_SETTLE;
                    end
                end
                // Oscillator settling before handling starts
                pdm_pkg::PDM_SETTLE: begin
                    if (!clr_pin_n) begin
                        state_next = pdm_pkg::PDM_RESET;
                    end else if (cnt_reg == '0) begin
                        state_next = pdm_pkg::PDM_RUN;
                    end
                end
                // Ports float until the pin sequence releases us
                pdm_pkg::PDM_HW_HW_STANDBY_PIN_N: begin
                    // Pin high alone is not enough; reset must also rise
                    if (!clr_pin_n) begin
                        state_next = pdm_pkg::PDM_RESET;
                    end
                end
                // Held while the reset pin stays low
                pdm_pkg::PDM_RESET: begin
                    if (clr_pin_n) begin
                        state_next = pdm_pkg::PDM_RUN;
                    end
                end
                default: state_next = pdm_pkg::PDM_RUN;
            endcase
        end
    end

    // State register
    // Synchronous reset only; pins never reset it directly
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_reg <= pdm_pkg::PDM_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Interrupt mask is sampled at the halt instruction
    // A later change of the CPU mask must not alter the sleep wake rule
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            imask_reg <= 1'b0;
        end else if (state_reg == pdm_pkg::PDM_RUN && i_halt_exec) begin
            imask_reg <= i_cpu_imask;
        end
    end

    // Settling counter: loaded on wake, counts states down to zero
    // Reloaded every cycle in software standby so no stale count survives
    // Loading N-1 makes the settling state last exactly N cycles
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cnt_reg <= '0;
        end else if (state_reg == pdm_pkg::PDM_SW_HW_STANDBY_PIN_N) begin
            cnt_reg <= settle_cnt - `PDM_CNT_W'(1);
        end else if (state_reg == pdm_pkg::PDM_SETTLE && cnt_reg != '0) begin
            cnt_reg <= cnt_reg - `PDM_CNT_W'(1);
        end
    end

    // Reset-source flag: i_rst_n and a pin rise both set it, so it always reads 1
    // Set once the pin is seen rising; nothing in this block clears it
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            clr_seen_reg <= 1'b0;
            rst_src_reg  <= 1'b1;
        end else begin
            clr_seen_reg <= ~clr_pin_n;
            if (clr_seen_reg && clr_pin_n) begin
                rst_src_reg <= 1'b1;
            end
        end
    end

    // Control register; modules are cleared in hardware standby
    // Writes in hardware standby or reset are lost by design
    // Software standby keeps the image so the select bit survives
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || state_reg == pdm_pkg::PDM_HW_HW_STANDBY_PIN_N
                     || state_reg == pdm_pkg::PDM_RESET) begin
            ctrl_reg <= `PDM_SYS_CTRL_RST;
        end else if (i_wr && i_addr == `PDM_OFS_SYS_CTRL) begin
            // Bit 3 is read-only; outside hardware standby and reset the select bit changes only here
            ctrl_reg <= (i_wdata & `PDM_WR_MASK)
                      | (ctrl_reg & ~`PDM_WR_MASK);
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    // Zero outside the answer cycle keeps a shared read bus quiet
    // Status shows the raw state code and whether the wait code is used
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd && i_addr == `PDM_OFS_SYS_CTRL) begin
            o_rdata <= {ctrl_reg[7:4], rst_src_reg, ctrl_reg[2:0]};
        end else if (i_rd && i_addr == `PDM_OFS_STATUS) begin
            o_rdata <= {4'h0, settle_ok, state_reg};
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // Registered outputs follow the next state, so each one lines up
    // with the state register in the same cycle
    // Fully stopped states: oscillator off, modules held in init
    function automatic logic stopped(input pdm_pkg::pdm_state_t s);
        return s == pdm_pkg::PDM_SW_HW_STANDBY_PIN_N || s == pdm_pkg::PDM_HW_HW_STANDBY_PIN_N;
    endfunction

    // Mode code for the outside world
    // Same encoding as the state enum, so no translation is needed
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_mode <= 3'h0;
        end else begin
            o_mode <= state_next;
        end
    end

    // CPU halted in every state but run
    // Sleep halts the CPU too, with its registers kept
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_cpu_halt <= 1'b0;
        end else begin
            o_cpu_halt <= state_next != pdm_pkg::PDM_RUN;
        end
    end

    // Clock to the chip only in run and sleep
    // High means the clock is let through
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_clk_gate_n <= 1'b1;
        end else begin
            o_clk_gate_n <= state_next == pdm_pkg::PDM_RUN
                         || state_next == pdm_pkg::PDM_SLEEP;
        end
    end

    // Oscillator off only while fully in standby
    // It runs again as soon as settling starts
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_osc_run <= 1'b1;
        end else begin
            o_osc_run <= !stopped(state_next);
        end
    end

    // Modules stay halted through settling as well
    // Sleep leaves them running
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_mod_halt <= 1'b0;
        end else begin
            o_mod_halt <= stopped(state_next)
                       || state_next == pdm_pkg::PDM_SETTLE;
        end
    end

    // Module initialisation in both standby modes
    // Released during settling so modules start clean
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_mod_init <= 1'b0;
        end else begin
            o_mod_init <= stopped(state_next);
        end
    end

    // Ports float in hardware standby only
    // Software standby keeps port levels held
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_port_hiz <= 1'b0;
        end else begin
            o_port_hiz <= state_next == pdm_pkg::PDM_HW_HW_STANDBY_PIN_N;
        end
    end

    // One-cycle pulse on interrupt wake from sleep or settling
    // Pin exits go through reset and never raise it
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_int_start <= 1'b0;
        end else begin
            o_int_start <= state_next == pdm_pkg::PDM_RUN
                        && (state_reg == pdm_pkg::PDM_SLEEP
                         || state_reg == pdm_pkg::PDM_SETTLE);
        end
    end

    // One-cycle pulse when reset pin rises
    // Starts the core's reset sequence
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_reset_seq <= 1'b0;
        end else begin
            o_reset_seq <= state_reg == pdm_pkg::PDM_RESET
                        && state_next == pdm_pkg::PDM_RUN;
        end
    end
endmodule

// ===== hw/pdm_defines.svh
// Offsets, field positions, reset values and timing counts of the controller
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH
`define PDM_ADDR_W          16
`define PDM_OFS_SYS_CTRL    16'hFFC4
`define PDM_OFS_STATUS      16'hFFC6
`define PDM_SYS_CTRL_RST    8'h09
`define PDM_BIT_HW_STANDBY_PIN_N_SEL    7
`define PDM_BIT_STS_HI      6
`define PDM_BIT_STS_LO      4
`define PDM_BIT_RST_SRC     3
`define PDM_WR_MASK         8'hF7
`define PDM_CNT_W           18
`define PDM_SETTLE_8K       18'h02000
`define PDM_SETTLE_16K      18'h04000
`define PDM_SETTLE_32K      18'h08000
`define PDM_SETTLE_64K      18'h10000
`define PDM_SETTLE_128K     18'h20000
`define PDM_SETTLE_1K       18'h00400
`endif

// ===== hw/pdm_pkg.sv
// Types shared by the power-down mode controller
package pdm_pkg;
    typedef enum logic [2:0] {
        PDM_RUN      = 3'h0,
        PDM_SLEEP    = 3'h1,
        PDM_SW_HW_STANDBY_PIN_N  = 3'h2,
        PDM_SETTLE   = 3'h3,
        PDM_HW_HW_STANDBY_PIN_N  = 3'h4,
        PDM_RESET    = 3'h5
    } pdm_state_t;
endpackage

// ===== hw/pdm_settle_decode.sv
// Settle-time code to state-count decoder
`timescale 1ns/1ps
`include "pdm_defines.svh"
module pdm_settle_decode (
    input  wire logic [2:0]               i_code,
    input  wire logic                     i_flash_variant,
    output logic      [`PDM_CNT_W-1:0]    o_count,
    output logic                          o_valid
);
    // Pure table; codes 11x report invalid
    always_comb begin
        o_valid = 1'b1;
        unique case (i_code)
            3'h0: o_count = `PDM_SETTLE_8K;
            3'h1: o_count = `PDM_SETTLE_16K;
            3'h2: o_count = `PDM_SETTLE_32K;
            3'h3: o_count = `PDM_SETTLE_64K;
            3'h4: o_count = `PDM_SETTLE_128K;
            3'h5: o_count = i_flash_variant ? `PDM_SETTLE_1K
                                            : `PDM_SETTLE_128K;
            default: begin
                // Unused codes: longest wait is the safe fallback
                o_count = `PDM_SETTLE_128K;
                o_valid = 1'b0;
            end
        endcase
    end
endmodule

// ===== hw/pdm_sync.sv
// Two-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
module pdm_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_reg;   // First stage, read only by second stage

    // Both stages reset to the idle level of the pin
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            meta_reg <= RST_VAL;
            o_sync   <= RST_VAL;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule

// ===== tb/pdm_cpu_model.sv
// CPU core, interrupt logic and pin drivers facing the controller
`timescale 1ns/1ps
module pdm_cpu_model (
    input  wire logic i_clk_sys,
    output logic      o_halt_exec,
    output logic      o_cpu_imask,
    output logic      o_int_req,
    output logic      o_nmi_req,
    output logic      o_ext_irq_req,
    output logic      o_chip_clear_pin_n,
    output logic      o_hw_standby_pin_n
);
    logic [2:0] req_reg; // Wake levels: enabled int, nmi, ext pins
    assign o_int_req     = req_reg[0];
    assign o_nmi_req     = req_reg[1];
    assign o_ext_irq_req = req_reg[2];
    // Quiet core, both pins released high
    initial begin
        {o_halt_exec, o_cpu_imask, req_reg} = 5'h00;
        {o_chip_clear_pin_n, o_hw_standby_pin_n} = 2'h3;
    end
    // Halt instruction for one cycle; mask driven to the given level and left there
    task automatic halt(input logic mask);
        @(posedge i_clk_sys);
        o_cpu_imask <= mask;
        o_halt_exec <= 1'b1;
        @(posedge i_clk_sys);
        o_halt_exec <= 1'b0;
    endtask
    // Wake request held two cycles, long enough to be sampled
    task automatic wake(input int idx);
        @(posedge i_clk_sys);
        req_reg[idx] <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        req_reg[idx] <= 1'b0;
    endtask
    // Pin levels; caller orders standby high before clear rises
    task automatic pins(input logic clr_n, input logic hw_standby_pin_n_n);
        @(posedge i_clk_sys);
        o_chip_clear_pin_n <= clr_n;
        o_hw_standby_pin_n <= hw_standby_pin_n_n;
    endtask
endmodule

// ===== tb/pdm_ctrl_asserts.sv
// Port-level assertions for the power-down mode controller
`timescale 1ns/1ps
module pdm_ctrl_asserts (
    input wire logic       i_clk_sys,
    input wire logic       i_rst_n,
    input wire logic       i_halt_exec,
    input wire logic       i_nmi_req,
    input wire logic       o_cpu_halt,
    input wire logic       o_clk_gate_n,
    input wire logic       o_osc_run,
    input wire logic       o_mod_halt,
    input wire logic       o_mod_init,
    input wire logic       o_port_hiz,
    input wire logic       o_int_start,
    input wire logic [2:0] o_mode
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    logic [17:0] stl_q; // Settling cycles so far, zero outside settling but for the cycle after it
    // Counter kept wide enough for the longest settling code
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || o_mode != 3'h3)
            stl_q <= 18'h00000;
        else
            stl_q <= stl_q + 18'h00001;
    end
    a_halt_enters: assert property (o_mode == 3'h0 && i_halt_exec |=>
        o_mode inside {3'h1, 3'h2, 3'h4, 3'h5}) else $error("halt lost");
    a_cpu_halted: assert property (o_cpu_halt == (o_mode != 3'h0))
        else $error("cpu halt flag wrong");
    a_sleep_runs: assert property (o_mode == 3'h1 |->
        o_clk_gate_n && !o_mod_halt) else $error("sleep stopped clock");
    a_swstby_stops: assert property (o_mode == 3'h2 |->
        !o_clk_gate_n && !o_osc_run && o_mod_init) else $error("standby");
    a_settle_osc: assert property (o_mode == 3'h3 |->
        o_osc_run && o_mod_halt) else $error("settling outputs wrong");
    a_hw_hiz: assert property (o_port_hiz == (o_mode == 3'h4))
        else $error("port float wrong");
    a_settle_min: assert property ($fell(o_mode == 3'h3) &&
        o_mode == 3'h0 |-> stl_q >= 18'h00400) else $error("settle short");
    a_wake_pulse: assert property (o_int_start |-> o_mode == 3'h0 &&
        $past(o_mode) inside {3'h1, 3'h3}) else $error("stray wake pulse");
    a_nmi_wakes: assert property (o_mode == 3'h1 && i_nmi_req |=>
        o_mode != 3'h1) else $error("nmi did not wake");
    a_hw_exit: assert property (o_mode == 3'h4 |=>
        o_mode inside {3'h4, 3'h5}) else $error("hw standby left wrongly");
    c_settle_done: cover property (o_mode == 3'h3 ##1 o_mode == 3'h0);
    c_sleep: cover property ($rose(o_mode == 3'h1));
    c_hw: cover property ($rose(o_mode == 3'h4));
endmodule
bind pdm_ctrl pdm_ctrl_asserts u_chk (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_halt_exec(i_halt_exec), .i_nmi_req(i_nmi_req),
    .o_cpu_halt(o_cpu_halt),
    .o_clk_gate_n(o_clk_gate_n), .o_osc_run(o_osc_run),
    .o_mod_halt(o_mod_halt), .o_mod_init(o_mod_init),
    .o_port_hiz(o_port_hiz), .o_int_start(o_int_start),
    .o_mode(o_mode));

// ===== tb/test_power_down_mode_controller.sv
// Self-checking bench for the power-down mode controller
`timescale 1ns/1ps
`include "pdm_defines.svh"
module test_power_down_mode_controller;
    localparam logic [15:0] CTRL = `PDM_OFS_SYS_CTRL;
    localparam logic [15:0] STAT = `PDM_OFS_STATUS;
    logic clk, rst_n, wr_s, rd_s, halt, imask, intr, nmi, ext;
    logic clr_n, hw_standby_pin_n_n, cpu_halt, gate_n, osc, mhalt, minit, hiz;
    logic int_start, rst_seq;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata;
    logic [2:0]  mode;
    int          error_cnt, n_checks, n;
    always #5 clk = ~clk;
    pdm_ctrl DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
        .i_halt_exec(halt), .i_cpu_imask(imask), .i_int_req(intr),
        .i_nmi_req(nmi), .i_ext_irq_req(ext), .i_chip_clear_pin_n(clr_n),
        .i_hw_standby_pin_n(hw_standby_pin_n_n), .o_cpu_halt(cpu_halt),
        .o_clk_gate_n(gate_n), .o_osc_run(osc), .o_mod_halt(mhalt),
        .o_mod_init(minit), .o_port_hiz(hiz), .o_int_start(int_start),
        .o_reset_seq(rst_seq), .o_mode(mode));
    pdm_cpu_model u_cpu (.i_clk_sys(clk), .o_halt_exec(halt),
        .o_cpu_imask(imask), .o_int_req(intr), .o_nmi_req(nmi),
        .o_ext_irq_req(ext), .o_chip_clear_pin_n(clr_n),
        .o_hw_standby_pin_n(hw_standby_pin_n_n));
    task automatic chk(input string what, input logic [17:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_at(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk("rdata", {10'h000, rdata}, {10'h000, exp});
    endtask
    task automatic rd(input logic [7:0] exp);
        rd_at(CTRL, exp);
    endtask
    // Bounded wait for a mode; running out ends the run
    task automatic wait_mode(input logic [2:0] m, input int b);
        int i;
        #1;
        for (i = 0; i < b && mode !== m; i++) begin
            @(posedge clk);
            #1;
        end
        chk("mode", {15'h0000, mode}, {15'h0000, m});
        if (mode !== m)
            end_sim();
    endtask
    // Clear pin low with standby high, then clear released
    task automatic leave_hw();
        u_cpu.pins(1'b0, 1'b1);
        wait_mode(3'h5, 6);
        u_cpu.pins(1'b1, 1'b1);
        wait_mode(3'h0, 6);
        chk("reset_seq", {17'h00000, rst_seq}, 18'h00001);
        rd(8'h09);
    endtask
    initial begin
        {clk, rst_n, wr_s, rd_s, addr, wdata} = 28'h0000000;
        {error_cnt, n_checks} = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h09);
        wr(CTRL, 8'h70);
        rd(8'h78);
        wr(CTRL + 16'h0001, 8'h80);
        rd(8'h78);
        wr(CTRL, 8'h60);
        rd_at(STAT, 8'h00);
        wr(CTRL, 8'h08);
        rd_at(STAT, 8'h08);
        $display("test registers done");
        u_cpu.halt(1'b0);
        wait_mode(3'h1, 4);
        rd_at(STAT, 8'h09);
        u_cpu.wake(0);
        wait_mode(3'h0, 4);
        u_cpu.halt(1'b1);
        wait_mode(3'h1, 4);
        u_cpu.wake(0);
        wait_mode(3'h1, 1);
        u_cpu.wake(1);
        wait_mode(3'h0, 4);
        $display("test sleep done");
        // Two shortest codes keep the run short
        for (int c = 0; c < 2; c++) begin
            wr(CTRL, {1'b1, c[2:0], 4'h8});
            u_cpu.halt(1'b0);
            wait_mode(3'h2, 4);
            fork u_cpu.wake(2); join_none
            wait_mode(3'h3, 4);
            n = 0;
            while (mode === 3'h3 && n < 20000) begin
                n++;
                @(posedge clk);
                #1;
            end
            chk("settle", n[17:0], 18'h02000 << c);
            chk("int_start", {17'h00000, int_start}, 18'h00001);
            rd({1'b1, c[2:0], 4'h8});
            wr(CTRL, 8'h08);
        end
        $display("test software standby done");
        u_cpu.halt(1'b0);
        wait_mode(3'h1, 4);
        u_cpu.pins(1'b0, 1'b1);
        wait_mode(3'h5, 6);
        u_cpu.pins(1'b1, 1'b1);
        wait_mode(3'h0, 6);
        u_cpu.halt(1'b0);
        wait_mode(3'h1, 4);
        u_cpu.pins(1'b1, 1'b0);
        wait_mode(3'h4, 6);
        chk("hiz", {17'h00000, hiz}, 18'h00001);
        leave_hw();
        wr(CTRL, 8'h88);
        u_cpu.halt(1'b0);
        wait_mode(3'h2, 4);
        u_cpu.pins(1'b1, 1'b0);
        wait_mode(3'h4, 6);
        leave_hw();
        $display("test pins done");
        end_sim();
    end
endmodule
